//--- hw/scc_pkg.sv
package scc_pkg;
	// =========================================================
	// register map
	localparam logic [7:0] SCC_ADDR_MGMT = 8'h00;
	localparam logic [7:0] SCC_ADDR_RESULT = 8'h04;
	localparam logic [7:0] SCC_ADDR_IRQEN = 8'h0c;
	localparam logic [7:0] SCC_ADDR_RAW = 8'h10;
	// =========================================================
	// management register fields
	localparam int SCC_GATE_BIT = 16;
	localparam int SCC_LVL_LSB = 13;
	localparam int SCC_REFSEL_BIT = 12;
	localparam int SCC_ENABLE_BIT = 11;
	localparam int SCC_DIV_LSB = 8;
	localparam int SCC_RES_BIT = 7;
	localparam int SCC_START_BIT = 6;
	localparam int SCC_DONE_BIT = 5;
	localparam int SCC_CHAN_LSB = 0;
	localparam int SCC_NUM_CHAN = 19;
	localparam logic [31:0] SCC_MGMT_RESET = 32'h0000_0000;
	localparam logic [18:0] SCC_FLAGS_RESET = 19'h0_0000;
	// =========================================================
	// timing
	localparam int SCC_WARMUP_US = 100;
	localparam int SCC_CLK_MHZ = 100;
	localparam int SCC_WARMUP_CYC = SCC_WARMUP_US * SCC_CLK_MHZ;
	localparam logic [4:0] SCC_STEPS_12 = 5'h10;
	localparam logic [4:0] SCC_STEPS_8 = 5'h0c;
	localparam logic [1:0] SCC_STEP_LAST = 2'h3;
	localparam logic [5:0] SCC_DIV_BY1 = 6'h00;
	// =========================================================
	// types
	typedef struct packed {
		logic gate;
		logic [2:0] level;
		logic ref_sel;
		logic enable;
		logic [2:0] div_sel;
		logic res;
		logic start;
		logic done;
		logic [4:0] chan;
	} scc_mgmt_t;
	typedef struct packed {
		logic start;
		logic [4:0] chan;
		logic res;
		logic powered;
		logic ref_sel;
		logic [2:0] level;
		logic gate;
	} scc_core_t;
	typedef enum logic [0:0] {
		SCC_IDLE = 1'b0,
		SCC_BUSY = 1'b1
	} scc_state_t;
endpackage

//--- hw/scc_top.sv
`timescale 1ns/10ps
module scc_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output scc_pkg::scc_core_t core_ctl,
	input wire logic core_done,
	input wire logic [11:0] core_result,
	output logic [15:0] pin_takeover,
	output logic irq
);
	import scc_pkg::*;

	// divider code to period in hclk cycles minus one
	function automatic logic [5:0] div_last(input logic [2:0] code);
		case (code)
			3'h1: div_last = 6'h01;
			3'h2: div_last = 6'h03;
			3'h3: div_last = 6'h07;
			3'h5: div_last = 6'h0f;
			3'h6: div_last = 6'h1f;
			default: div_last = SCC_DIV_BY1;
		endcase
	endfunction

	// =========================================================
	// bus address phase capture
	logic wr_pend_q, wr_pend_d;
	logic [7:0] addr_q, addr_d;
	logic [31:0] hrdata_q, hrdata_d;
	scc_mgmt_t mgmt_q, mgmt_d;
	logic [18:0] irqen_q, irqen_d, raw_q, raw_d;
	logic [11:0] result_q, result_d;
	scc_state_t state_q, state_d;
	logic [5:0] div_q, div_d;
	logic [1:0] sub_q, sub_d;
	logic [4:0] step_q, step_d;
	logic strobe_q, strobe_d;
	logic [15:0] take_q, take_d;
	logic irq_q, irq_d;
	logic done_s1_q, done_s2_q, done_s3_q;
	logic [11:0] res_s1_q, res_s2_q;
	logic conv_end, start_wr;
	logic [5:0] div_top;
	logic [4:0] steps;

	// done edge and result from the analog core pass two flip-flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
			done_s3_q <= 1'b0;
			res_s1_q <= 12'h000;
			res_s2_q <= 12'h000;
		end else begin
			done_s1_q <= core_done;
			done_s2_q <= done_s1_q;
			done_s3_q <= done_s2_q;
			res_s1_q <= core_result;
			res_s2_q <= res_s1_q;
		end
	end

	// register file and bus next state
	always_comb begin
		wr_pend_d = 1'b0;
		addr_d = addr_q;
		hrdata_d = hrdata_q;
		mgmt_d = mgmt_q;
		irqen_d = irqen_q;
		raw_d = raw_q;
		result_d = result_q;
		start_wr = 1'b0;
		// writes land at the end of their data phase
		if (hsel && hready && htrans[1]) begin
			wr_pend_d = hwrite;
			addr_d = haddr[7:0];
		end
		if (wr_pend_q) begin
			unique case (addr_q)
				SCC_ADDR_MGMT: begin
					// done and start keep their own behaviour below
					mgmt_d = hwdata[16:0];
					mgmt_d.done = mgmt_q.done;
					mgmt_d.start = mgmt_q.start | hwdata[SCC_START_BIT];
					start_wr = hwdata[SCC_START_BIT] && !mgmt_q.start;
				end
				SCC_ADDR_IRQEN: irqen_d = hwdata[18:0];
				SCC_ADDR_RAW: raw_d = raw_q & hwdata[18:0];
				default: ;
			endcase
		end
		if (start_wr) begin
			mgmt_d.done = 1'b0;
		end
		if (conv_end) begin
			mgmt_d.start = 1'b0;
			mgmt_d.done = 1'b1;
			result_d = res_s2_q;
			if (mgmt_q.chan < 5'(SCC_NUM_CHAN)) begin
				raw_d[mgmt_q.chan] = 1'b1;
			end
		end
		if (!mgmt_d.enable) begin
			mgmt_d.start = 1'b0;
		end
		// read data is fetched in the address phase from the next values,
		// so it stands through the whole data phase with zero wait states
		// and already shows a write finishing in the same cycle
		if (hsel && hready && htrans[1] && !hwrite) begin
			unique case (haddr[7:0])
				SCC_ADDR_MGMT: hrdata_d = {15'h0000, mgmt_d};
				SCC_ADDR_RESULT: hrdata_d = {20'h00000, result_d};
				SCC_ADDR_IRQEN: hrdata_d = {13'h0000, irqen_d};
				SCC_ADDR_RAW: hrdata_d = {13'h0000, raw_d};
				default: hrdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			addr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
			mgmt_q <= scc_mgmt_t'(SCC_MGMT_RESET[16:0]);
			irqen_q <= SCC_FLAGS_RESET;
			raw_q <= SCC_FLAGS_RESET;
			result_q <= 12'h000;
		end else begin
			wr_pend_q <= wr_pend_d;
			addr_q <= addr_d;
			hrdata_q <= hrdata_d;
			mgmt_q <= mgmt_d;
			irqen_q <= irqen_d;
			raw_q <= raw_d;
			result_q <= result_d;
		end
	end

	// =========================================================
	// conversion sequencer: divided clock, four ticks per step
	assign div_top = div_last(mgmt_q.div_sel);
	assign steps = mgmt_q.res ? SCC_STEPS_12 : SCC_STEPS_8;
	assign conv_end = (state_q == SCC_BUSY) && (step_q == steps)
		&& done_s2_q && !done_s3_q;

	always_comb begin
		state_d = state_q;
		div_d = div_q;
		sub_d = sub_q;
		step_d = step_q;
		strobe_d = 1'b0;
		unique case (state_q)
			SCC_IDLE: begin
				if (mgmt_q.start && mgmt_q.enable) begin
					state_d = SCC_BUSY;
					div_d = 6'h00;
					sub_d = 2'h0;
					step_d = 5'h00;
					strobe_d = 1'b1;
				end
			end
			SCC_BUSY: begin
				if (!mgmt_q.enable || conv_end) begin
					state_d = SCC_IDLE;
				end else if (step_q != steps) begin
					if (div_q == div_top) begin
						div_d = 6'h00;
						sub_d = sub_q + 2'h1;
						if (sub_q == SCC_STEP_LAST) begin
							step_d = step_q + 5'h01;
						end
					end else begin
						div_d = div_q + 6'h01;
					end
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= SCC_IDLE;
			div_q <= 6'h00;
			sub_q <= 2'h0;
			step_q <= 5'h00;
			strobe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			div_q <= div_d;
			sub_q <= sub_d;
			step_q <= step_d;
			strobe_q <= strobe_d;
		end
	end

	// =========================================================
	// pin takeover and interrupt
	always_comb begin
		take_d = 16'h0000;
		if (mgmt_q.enable && mgmt_q.gate && !mgmt_q.chan[4]) begin
			take_d[mgmt_q.chan[3:0]] = 1'b1;
		end
		if (mgmt_q.ref_sel) begin
			take_d[0] = 1'b1;
		end
		irq_d = |(raw_q & irqen_q);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			take_q <= 16'h0000;
			irq_q <= 1'b0;
		end else begin
			take_q <= take_d;
			irq_q <= irq_d;
		end
	end

	// outputs
	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign pin_takeover = take_q;
	assign irq = irq_q;
	assign core_ctl = '{start: strobe_q, chan: mgmt_q.chan,
		res: mgmt_q.res, powered: mgmt_q.enable,
		ref_sel: mgmt_q.ref_sel, level: mgmt_q.level,
		gate: mgmt_q.gate};

	// =========================================================
	// checks
	// a start write that keeps the converter powered
	sequence start_write_s;
		wr_pend_q && addr_q == SCC_ADDR_MGMT && hwdata[SCC_START_BIT]
			&& hwdata[SCC_ENABLE_BIT] && !mgmt_q.start && mgmt_q.enable;
	endsequence
	// done drops at once, the core strobe follows a cycle later
	sequence clear_then_strobe_s;
		!mgmt_q.done ##1 strobe_q;
	endsequence
	// read address phases of the status word and the result word
	sequence read_mgmt_s;
		hsel && hready && htrans[1] && !hwrite
			&& haddr[7:0] == SCC_ADDR_MGMT;
	endsequence
	sequence read_result_s;
		hsel && hready && htrans[1] && !hwrite
			&& haddr[7:0] == SCC_ADDR_RESULT;
	endsequence

	start_clears_done_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		start_write_s |=> clear_then_strobe_s)
		else $error("start did not clear done or strobe core");
	end_sets_done_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		conv_end |=> mgmt_q.done && !mgmt_q.start)
		else $error("end of conversion did not update status");
	result_capture_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		conv_end |=> result_q == $past(res_s2_q))
		else $error("result not captured");
	raw_flag_set_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		conv_end && mgmt_q.chan < 5'(SCC_NUM_CHAN)
			|=> raw_q[$past(mgmt_q.chan)])
		else $error("raw flag not set");
	disable_stops_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!mgmt_q.enable |-> !mgmt_q.start)
		else $error("start held while disabled");
	takeover_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		mgmt_q.enable && mgmt_q.gate && mgmt_q.chan == 5'h03
			|=> pin_takeover[3])
		else $error("pin not taken over");
	release_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!mgmt_q.gate && !mgmt_q.ref_sel |=> pin_takeover == 16'h0000)
		else $error("pin not released");
	fast_min_time_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		strobe_q && mgmt_q.div_sel == 3'h0 && !mgmt_q.res
			|-> !conv_end [*8])
		else $error("conversion ended too early");
	irq_gate_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		(raw_q & irqen_q) == 19'h0_0000 |=> !irq)
		else $error("irq without enabled flag");
	status_read_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		read_mgmt_s |=> hrdata == {15'h0000, mgmt_q})
		else $error("status read does not match register");
	result_read_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		read_result_s |=> hrdata == {20'h00000, result_q})
		else $error("result read does not match buffer");
	strobe_pulse_a: assert property (
		@(posedge hclk) disable iff (!hresetn)
		strobe_q |=> !strobe_q)
		else $error("core start strobe longer than one cycle");
endmodule // scc_top

//--- verification/scc_core_model.sv
`timescale 1ns/10ps
module scc_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input scc_pkg::scc_core_t ctl,
	input wire logic [15:0] lat,
	output logic done,
	output logic [11:0] result
);
	import scc_pkg::*;
	logic [15:0] cnt_q;
	// ==========================================
	// answer lat cycles after a start pulse
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 16'h0000;
			done <= 1'b0;
			result <= 12'h000;
		end else begin
			cnt_q <= ctl.start ? lat + 16'h0008 : cnt_q - {15'h0, cnt_q != 0};
			done <= cnt_q inside {[16'h0005:16'h0008]};
			// word steady before done rises, toggling when released
			if (cnt_q == 16'h0009)
				result <= {1'b1, ctl.chan, 6'h35};
			else if (cnt_q > 16'h0009 || cnt_q == 16'h0000)
				result <= ~result;
		end
	end
endmodule // scc_core_model

//--- verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import scc_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, core_done, irq;
	logic [11:0] core_result;
	logic [15:0] pin_takeover;
	logic [15:0] lat = 16'h0040;
	scc_core_t core_ctl;
	logic [7:0] adrs [4] = '{SCC_ADDR_MGMT, SCC_ADDR_IRQEN, SCC_ADDR_RAW, 8'h08};
	int divs [8] = '{1, 2, 4, 8, 1, 16, 32, 1};
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int t0;
	// ==========================================
	// clock, cycle count and instances
	always #5 hclk = ~hclk;
	always @(posedge hclk) cyc <= cyc + 1;
	scc_top u_scc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .core_ctl(core_ctl),
		.core_done(core_done), .core_result(core_result),
		.pin_takeover(pin_takeover), .irq(irq));
	scc_core_model u_scc_core_model (.hclk(hclk), .hresetn(hresetn),
		.ctl(core_ctl), .lat(lat), .done(core_done), .result(core_result));
	// ==========================================
	// verdict, compares and bus cycles
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_time(input int got, input int lo);
		n_checks++;
		if (got < lo || got > lo + 24) begin
			bad_count++;
			$display("FAIL t=%0t cycles %h min %h", $time, got, lo);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// start, check done clear, poll done, check duration and status
	task automatic convert(input logic [31:0] cfg, input int e);
		lat <= 16'(e + 4);
		bus(1'b1, SCC_ADDR_MGMT, cfg);
		t0 = cyc;
		bus(1'b0, SCC_ADDR_MGMT, 32'h0);
		cmp(rd & 32'h60, 32'h40);
		repeat (3000) if (rd[5] !== 1'b1) bus(1'b0, SCC_ADDR_MGMT, 32'h0);
		cmp_time(cyc - t0, e);
		cmp(rd, (cfg & ~32'h40) | 32'h20);
	endtask
	// ==========================================
	// main sequence
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		cmp({3'h0, core_ctl, pin_takeover}, 32'h0);
		cmp({30'h0, hreadyout, hresp}, 32'h2);
		bus(1'b1, 8'h08, 32'hffff_ffff);
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, adrs[i], 32'h0);
			cmp(rd, 32'h0);
		end
		bus(1'b1, SCC_ADDR_MGMT, 32'h0000_0040);
		bus(1'b0, SCC_ADDR_MGMT, 32'h0);
		cmp(rd, 32'h0);
		// one input pin only, pad taken over by the converter
		bus(1'b1, SCC_ADDR_MGMT, 32'h0001_0803);
		bus(1'b0, SCC_ADDR_MGMT, 32'h0);
		cmp(rd, 32'h0001_0803);
		cmp({16'h0, pin_takeover}, 32'h8);
		cmp({19'h0, core_ctl}, {19'h0, 13'b0_00011_0_1_0_000_1});
		repeat (SCC_WARMUP_CYC) @(posedge hclk);
		bus(1'b1, SCC_ADDR_MGMT, 32'h0000_0803);
		// the write lands at the last edge, the pin map one edge later
		repeat (2) @(posedge hclk);
		cmp({16'h0, pin_takeover}, 32'h0);
		for (int lv = 0; lv < 8; lv++) begin
			bus(1'b1, SCC_ADDR_MGMT, 32'h0001_1803 | (lv << 13));
			repeat (2) @(posedge hclk);
			cmp({29'h0, core_ctl.level}, 32'(lv));
			cmp({16'h0, pin_takeover}, 32'h9);
		end
		convert(32'h0001_08c3, 64);
		bus(1'b1, SCC_ADDR_RESULT, 32'h0);
		bus(1'b0, SCC_ADDR_RESULT, 32'h0);
		cmp(rd, {20'h0, 1'b1, 5'h03, 6'h35});
		bus(1'b0, SCC_ADDR_RAW, 32'h0);
		cmp({rd[30:0], irq}, 32'h10);
		bus(1'b1, SCC_ADDR_IRQEN, 32'h8);
		bus(1'b0, SCC_ADDR_RAW, 32'h0);
		cmp({31'h0, irq}, 32'h1);
		bus(1'b1, SCC_ADDR_RAW, 32'h0);
		bus(1'b0, SCC_ADDR_RAW, 32'h0);
		cmp({rd[30:0], irq}, 32'h0);
		// internal level channel with supply reference, 8-bit, every divider
		for (int k = 0; k < 8; k++) begin
			convert(32'h0001_8850 | (k << 8), 48 * divs[k]);
			bus(1'b0, SCC_ADDR_RESULT, 32'h0);
			cmp(rd & 32'hff0, {20'h0, 1'b1, 5'h10, 6'h30});
		end
		end_of_test();
	end
	// ==========================================
	// watchdog cuts a hang short
	initial begin
		repeat (40000) @(posedge hclk);
		bad_count++;
		end_of_test();
	end
endmodule // tb_top
